// ==== pkg/osr_defs.vh ====
// Purpose: Constants for the operation status register group
// Assumes: Included by bare name from hdl/ and dv/ files
// Notes: Command codes are local choices; bit positions follow the register layout
`ifndef OSR_DEFS_VH
`define OSR_DEFS_VH

// Register width
`define OSR_WIDTH 16

// Host command codes on the command port
`define OSR_CMD_NONE 3'h0
`define OSR_CMD_READ_COND 3'h1
`define OSR_CMD_WRITE_MASK 3'h2
`define OSR_CMD_READ_MASK 3'h3
`define OSR_CMD_READ_EVENTS 3'h4
`define OSR_CMD_PRESET 3'h5

// Operation register bit positions
`define OSR_BIT_AUX0 0
`define OSR_BIT_AUX5 5
`define OSR_BIT_VOLT_MODE 8
`define OSR_BIT_CURR_MODE 10

// Implemented bits (1 + 32 + 256 + 1024 = 1313)
`define OSR_OPER_MASK 16'h0521

// Questionable condition bit positions
`define OSR_QBIT_VOLT_MODE 0
`define OSR_QBIT_CURR_MODE 1
`define OSR_QBIT_VOLT_ERR 12
`define OSR_QBIT_CURR_ERR 13
`define OSR_QUES_MASK 16'h3003

// Reset values
`define OSR_RESET_VALUE 16'h0000

`endif

// ==== hdl/osr_edge_latch.v ====
// Purpose: Rising-edge event latch with clear-on-read
// Assumes: Conditions are synchronous to mclk
// Notes: A new event in the clear cycle survives the clear
`timescale 1ns/1ps
`default_nettype none
`include "osr_defs.vh"
module osr_edge_latch #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input wire mclk,
    input wire arst_n,
    // Condition and control
    input wire [WIDTH-1:0] condBits,
    input wire clearAll,
    // Latched events
    output reg [WIDTH-1:0] eventBits
);
    reg [WIDTH-1:0] condLast;
    wire [WIDTH-1:0] riseBits;

    // Rising edges of the live condition
    assign riseBits = condBits & ~condLast;

    // Set wins over the clear so no event is dropped
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            condLast <= {WIDTH{1'b0}};
            eventBits <= {WIDTH{1'b0}};
        end else begin
            condLast <= condBits;
            eventBits <= (clearAll ? {WIDTH{1'b0}} : eventBits) | riseBits;
        end
    end
endmodule
`default_nettype wire

// ==== hdl/osr_pin_sync.v ====
// Purpose: Two-flop synchroniser for a bus of status pins
// Assumes: Each bit is an independent level
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module osr_pin_sync #(
    parameter WIDTH = 4
) (
    // Clock and reset
    input wire mclk,
    input wire arst_n,
    // Asynchronous levels in, synchronised out
    input wire [WIDTH-1:0] asyncIn,
    output reg [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stageOne;

    // Metastability guard
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stageOne <= {WIDTH{1'b0}};
            syncOut <= {WIDTH{1'b0}};
        end else begin
            stageOne <= asyncIn;
            syncOut <= stageOne;
        end
    end
endmodule
`default_nettype wire

// ==== hdl/osr_status_group.v ====
// Purpose: Operation status register group with summary bit
// Assumes: Host commands arrive as one-cycle strobes on mclk
// Notes: Questionable condition kept only as far as preset needs
`timescale 1ns/1ps
`default_nettype none
`include "osr_defs.vh"

// Operation
// - Condition register reflects live operating state, unlatched.
// - Bit 10 is current mode, bit 8 voltage mode.
// - Returned values only use bits weighted 1, 32, 256, 1024.
// - A one means active or enabled; host masks use same polarity.
// - Mask write stores value and gates events into summary.
// - Summary bit 7 is OR of enabled event bits.
// - Mask query returns the stored mask exactly.
// - Event register is read-only; rising edges latch until read.
// - Event read returns contents then clears them.
// - Preset zeroes operation and questionable condition registers.
// - Questionable bits: 13 current error, 12 voltage error, 1, 0 modes.
module osr_status_group #(
    parameter WIDTH = `OSR_WIDTH
) (
    // Clock and reset
    input wire mclk,
    input wire arst_n,
    // Operating state pins
    input wire currentModeIn,
    input wire voltageModeIn,
    input wire aux0In,
    input wire aux5In,
    input wire currentErrIn,
    input wire voltageErrIn,
    // Host command port
    input wire cmdValid,
    input wire [2:0] cmdCode,
    input wire [WIDTH-1:0] cmdData,
    // Host answer port
    output reg rspValid,
    output reg [WIDTH-1:0] rspData,
    // Status byte summaries and questionable view
    output wire operSummary,
    output reg [WIDTH-1:0] quesCondition,
    output wire [WIDTH-1:0] quesEvents
);
    wire [5:0] pinsSync;
    reg presetHold;
    reg [WIDTH-1:0] operCondition;
    reg [WIDTH-1:0] operMask;
    wire [WIDTH-1:0] operEvents;
    wire [WIDTH-1:0] liveOper;
    wire [WIDTH-1:0] liveQues;
    wire cmdPreset;
    wire cmdEvtRead;
    wire cmdMaskWrite;
    reg quesReadPulse;

    // Pins come from the analog side, so synchronise first
    osr_pin_sync #(.WIDTH(6)) pinSync (
        .mclk(mclk),
        .arst_n(arst_n),
        .asyncIn({voltageErrIn, currentErrIn, aux5In, aux0In, voltageModeIn, currentModeIn}),
        .syncOut(pinsSync)
    );

    // Decoded command strobes
    assign cmdPreset = cmdValid && (cmdCode == `OSR_CMD_PRESET);
    assign cmdEvtRead = cmdValid && (cmdCode == `OSR_CMD_READ_EVENTS);
    assign cmdMaskWrite = cmdValid && (cmdCode == `OSR_CMD_WRITE_MASK);

    // Live operation word, only implemented weights
    assign liveOper = ({{(WIDTH-1){1'b0}}, pinsSync[0]} << `OSR_BIT_CURR_MODE)
        | ({{(WIDTH-1){1'b0}}, pinsSync[1]} << `OSR_BIT_VOLT_MODE)
        | ({{(WIDTH-1){1'b0}}, pinsSync[2]} << `OSR_BIT_AUX0)
        | ({{(WIDTH-1){1'b0}}, pinsSync[3]} << `OSR_BIT_AUX5);

    // Live questionable word
    assign liveQues = ({{(WIDTH-1){1'b0}}, pinsSync[4]} << `OSR_QBIT_CURR_ERR)
        | ({{(WIDTH-1){1'b0}}, pinsSync[5]} << `OSR_QBIT_VOLT_ERR)
        | ({{(WIDTH-1){1'b0}}, pinsSync[0]} << `OSR_QBIT_CURR_MODE)
        | ({{(WIDTH-1){1'b0}}, pinsSync[1]} << `OSR_QBIT_VOLT_MODE);

    // Preset forces conditions to zero until the live word differs from them,
    // so any active pins come back as fresh edges two cycles after the preset
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            presetHold <= 1'b0;
        end else if (cmdPreset) begin
            presetHold <= 1'b1;
        end else if (presetHold && ({liveOper, liveQues} != {operCondition, quesCondition})) begin
            presetHold <= 1'b0;
        end
    end

    // Condition registers follow the pins each cycle except while a preset or its hold zeroes them
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            operCondition <= `OSR_RESET_VALUE;
            quesCondition <= `OSR_RESET_VALUE;
        end else if (cmdPreset) begin
            operCondition <= `OSR_RESET_VALUE;
            quesCondition <= `OSR_RESET_VALUE;
        end else if (presetHold) begin
            operCondition <= `OSR_RESET_VALUE;
            quesCondition <= `OSR_RESET_VALUE;
        end else begin
            operCondition <= liveOper & `OSR_OPER_MASK;
            quesCondition <= liveQues & `OSR_QUES_MASK;
        end
    end

    // Enable mask written by host
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            operMask <= `OSR_RESET_VALUE;
        end else if (cmdMaskWrite) begin
            operMask <= cmdData & `OSR_OPER_MASK;
        end
    end

    // Operation event latch, cleared by the event query
    osr_edge_latch #(.WIDTH(WIDTH)) operLatch (
        .mclk(mclk),
        .arst_n(arst_n),
        .condBits(operCondition),
        .clearAll(cmdEvtRead),
        .eventBits(operEvents)
    );

    // Questionable latch only holds the two error bits, no host query here
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            quesReadPulse <= 1'b0;
        end else begin
            quesReadPulse <= 1'b0;
        end
    end
    osr_edge_latch #(.WIDTH(WIDTH)) quesLatch (
        .mclk(mclk),
        .arst_n(arst_n),
        .condBits(quesCondition & (16'h0001 << `OSR_QBIT_CURR_ERR | 16'h0001 << `OSR_QBIT_VOLT_ERR)),
        .clearAll(quesReadPulse),
        .eventBits(quesEvents)
    );

    // Summary bit 7 of the status byte
    assign operSummary = |(operEvents & operMask);

    // Answers: one cycle after the query, registered
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rspValid <= 1'b0;
            rspData <= `OSR_RESET_VALUE;
        end else begin
            rspValid <= 1'b0;
            if (cmdValid && cmdCode == `OSR_CMD_READ_COND) begin
                rspValid <= 1'b1;
                rspData <= operCondition & `OSR_OPER_MASK;
            end else if (cmdValid && cmdCode == `OSR_CMD_READ_MASK) begin
                rspValid <= 1'b1;
                rspData <= operMask;
            end else if (cmdEvtRead) begin
                rspValid <= 1'b1;
                rspData <= operEvents & `OSR_OPER_MASK;
            end
        end
    end
endmodule
`default_nettype wire

// ==== dv/osr_status_props.sv ====
// Purpose: Port assertions for the status register group
// Assumes: Query answers land one edge after the taking edge
// Notes: Bound onto every osr_status_group
`timescale 1ns/1ps
`default_nettype none
`include "osr_defs.vh"
module osr_status_props #(
    parameter WIDTH = 16
) (
    // Clock, reset and host side
    input wire mclk,
    input wire arst_n,
    input wire cmdValid,
    input wire [2:0] cmdCode,
    input wire [WIDTH-1:0] cmdData,
    // Answers and summaries
    input wire rspValid,
    input wire [WIDTH-1:0] rspData,
    input wire operSummary,
    input wire [WIDTH-1:0] quesCondition,
    input wire [WIDTH-1:0] quesEvents
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // Only three codes expect an answer
    wire isQuery = cmdValid && (cmdCode == 3'h1 || cmdCode == 3'h3 || cmdCode == 3'h4);
    wire isWr = cmdValid && cmdCode == `OSR_CMD_WRITE_MASK;
    chk_query_answer: assert property (isQuery |=> rspValid)
        else $error("query not answered");
    chk_silent_cmds: assert property (cmdValid && !isQuery |=> !rspValid)
        else $error("answer without query");
    chk_answer_range: assert property (rspValid |-> (rspData & ~`OSR_OPER_MASK) == 16'h0000)
        else $error("answer outside implemented bits");
    chk_mask_echo: assert property (isWr ##1 (cmdValid && cmdCode == 3'h3) |=>
        rspData == ($past(cmdData, 2) & `OSR_OPER_MASK))
        else $error("mask readback differs");
    chk_summary_off: assert property (isWr && cmdData == 16'h0000 |=> !operSummary)
        else $error("summary with empty mask");
    chk_ques_layout: assert property ((quesCondition & ~`OSR_QUES_MASK) == 16'h0000)
        else $error("questionable bit misplaced");
    chk_ques_latch: assert property ((quesEvents & 16'hcfff) == 16'h0000)
        else $error("questionable mode bit latched");
    chk_reset_quiet: assert property ($rose(arst_n) |-> !rspValid && !operSummary)
        else $error("outputs busy after reset");
    cover property (isQuery ##1 rspValid);
    cover property (cmdValid && cmdCode == `OSR_CMD_PRESET);
    cover property (operSummary);
endmodule
bind osr_status_group osr_status_props #(.WIDTH(WIDTH)) osr_status_props_inst (.mclk, .arst_n,
    .cmdValid, .cmdCode, .cmdData, .rspValid, .rspData, .operSummary, .quesCondition,
    .quesEvents);
`default_nettype wire

// ==== dv/osr_host_model.sv ====
// Purpose: Host model issuing status commands
// Assumes: Called just after a rising edge
// Notes: Code zero gives an idle cycle
`timescale 1ns/1ps
`default_nettype none
module osr_host_model (
    // Clock and answer
    input wire logic mclk,
    input wire logic rspValid,
    input wire logic [15:0] rspData,
    // Command port
    output logic cmdValid = 1'b0,
    output logic [2:0] cmdCode = 3'h0,
    output logic [15:0] cmdData = 16'h0000
);
    // One command per call; left raised so back-to-back calls with non-zero codes never toggle it
    task automatic xfer(input logic [2:0] c, input logic [15:0] d, output logic g,
        output logic [15:0] r);
        cmdValid = (c != 3'h0);
        cmdCode = c;
        cmdData = d;
        @(posedge mclk);
        #1;
        g = rspValid;
        r = rspData;
    endtask
    // Idle: data flipped so a stale word is never mistaken for a fresh one
    task automatic idle(input int n);
        cmdValid = 1'b0;
        cmdData = ~cmdData;
        repeat (n) @(posedge mclk);
        #1;
    endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Purpose: Random and corner tests of the status register group
// Assumes: Pin changes reach the event latch within six cycles
// Notes: Seed fixed at 44
`timescale 1ns/1ps
`default_nettype none
`include "osr_defs.vh"
module testbench;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [5:0] pins = 6'h00;
    wire cmdValid, rspValid, operSummary;
    wire [2:0] cmdCode;
    wire [15:0] cmdData, rspData, quesCond, quesEv;
    logic [15:0] qcond = 16'h0000, qev = 16'h0000;
    logic [15:0] cond = 16'h0000, ev = 16'h0000, mask = 16'h0000, rd;
    logic got;
    int fails = 0, checked = 0, cyc = 0;
    always #10 mclk = ~mclk;
    osr_status_group osr_status_group_inst (.mclk(mclk), .arst_n(arst_n),
        .currentModeIn(pins[3]), .voltageModeIn(pins[2]), .aux5In(pins[1]), .aux0In(pins[0]),
        .currentErrIn(pins[5]), .voltageErrIn(pins[4]), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData), .operSummary(operSummary),
        .quesCondition(quesCond), .quesEvents(quesEv));
    osr_host_model osr_host_model_inst (.mclk(mclk), .rspValid(rspValid), .rspData(rspData),
        .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData));
    // Pins to operation word: 10 current, 8 voltage, 5 and 0 aux
    function automatic logic [15:0] opWord(input logic [3:0] p);
        opWord = {5'h00, p[3], 1'b0, p[2], 2'h0, p[1], 4'h0, p[0]};
    endfunction
    // Pins to questionable word: 13 current error, 12 voltage error, 1 and 0 modes
    function automatic logic [15:0] qWord(input logic [5:0] p);
        qWord = {2'h0, p[5], p[4], 10'h000, p[3], p[2]};
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        checked++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic settle(input logic [5:0] p);
        pins = p;
        osr_host_model_inst.idle(6);
        ev = ev | (opWord(p[3:0]) & ~cond);
        cond = opWord(p[3:0]);
        chk("summary", {15'h0, |(ev & mask)}, {15'h0, operSummary});
        qev = qev | (qWord(p) & 16'h3000 & ~qcond);
        qcond = qWord(p);
        chk("quesCond", qcond, quesCond);
        chk("quesEvents", qev, quesEv);
    endtask
    task automatic run(input logic [2:0] c, input logic [15:0] d);
        osr_host_model_inst.xfer(c, d, got, rd);
        chk("answer", {15'h0, c == 3'h1 || c == 3'h3 || c == 3'h4}, {15'h0, got});
        if (c == 3'h1) chk("cond", cond, rd);
        if (c == 3'h3) chk("mask", mask, rd);
        if (c == 3'h4) chk("events", ev, rd);
        if (c == 3'h4) ev = 16'h0000;
        if (c == 3'h2) mask = d & `OSR_OPER_MASK;
        if (c == 3'h5) begin
            // Preset drops the word; live pins then bring it back as fresh rises
            osr_host_model_inst.idle(6);
            ev = ev | cond;
            qev = qev | (qcond & 16'h3000);
        end
    endtask
    task give_verdict;
        if (fails == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            give_verdict;
        end
    end
    initial begin
        cyc = $urandom(44);
        cyc = 0;
        repeat (4) @(posedge mclk);
        #1;
        arst_n = 1'b1;
        // Corners: empty mask, dropped bits echo, double event read, preset
        settle(6'h3f);
        run(3'h2, 16'h0000);
        run(3'h2, 16'hffff);
        run(3'h3, 16'h0000);
        settle(6'h3f);
        run(3'h4, 16'h0000);
        run(3'h4, 16'h0000);
        settle(6'h00);
        run(3'h5, 16'h0000);
        run(3'h1, 16'h0000);
        repeat (150) begin
            settle(6'($urandom));
            run(3'($urandom), 16'($urandom));
        end
        give_verdict;
    end
endmodule
`default_nettype wire
